// >>> rtl/cae_exec.sv
// Arithmetic execution unit with operand addressing and code cache
`timescale 1ns/1ps
module cae_exec #(
    parameter int CACHE_DEPTH = cae_pkg::CACHE_BYTES
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_issue,
    input wire cae_pkg::cae_instr_t i_instr,
    input wire logic [1:0] i_bank_sel,
    output logic o_ready,
    output logic o_done,
    output logic [1:0] o_len,
    output logic [7:0] o_acc,
    output logic [7:0] o_aux,
    output logic [15:0] o_wp,
    output cae_pkg::cae_flags_t o_flags,
    output logic o_mem_rd_en,
    output logic o_mem_wr_en,
    output logic [7:0] o_mem_addr,
    output logic [7:0] o_mem_wdata,
    input wire logic [7:0] i_mem_rdata,
    input wire logic i_fetch_req,
    input wire logic [15:0] i_fetch_addr,
    output logic o_fetch_valid,
    output logic [7:0] o_fetch_data,
    output logic o_flash_rd,
    output logic [15:0] o_flash_addr,
    input wire logic i_flash_ack,
    input wire logic [7:0] i_flash_data
);
    // ******************************************************
    // Declarations
    // ******************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_CODE = 2'b10
    } cae_state_t;

    cae_state_t st_reg, st_next;
    logic [2:0] cnt_reg, cnt_next;
    cae_pkg::cae_instr_t ir_reg;
    logic [7:0] bank_mem [32];
    logic int_rd_reg, idx_sent_reg;
    logic take, commit, mid, code_req, c_ack, c_idle, own_ack;
    logic [15:0] code_addr;
    logic [7:0] c_data, ptr, rd_addr, opnd, res;
    logic need_mem;
    logic [8:0] sum9, dif9;
    logic [4:0] sum5, dif5;
    logic [15:0] prod;
    logic [7:0] da1, da2;
    logic da_lo, da_hi;

    assign take = i_issue && o_ready;
    assign commit = (st_reg == ST_RUN) && (cnt_reg == 3'h1);
    assign mid = (st_reg == ST_RUN) && (cnt_reg == 3'h2);
    assign own_ack = c_ack && (st_reg == ST_CODE) && idx_sent_reg;

    // ******************************************************
    // Operand addressing
    // ******************************************************
    // Pointer is R0 or R1 of the selected bank
    assign ptr = bank_mem[{i_bank_sel, 2'b00, i_instr.reg_idx[0]}];
    always_comb begin
        rd_addr = i_instr.byte1;
        if (i_instr.op == cae_pkg::OP_BITLD) begin
            // Low half maps onto RAM bytes, high half onto Special_function_registers
            rd_addr = i_instr.byte1[cae_pkg::BIT_SFR_FLAG] ?
                {i_instr.byte1[7:3], 3'b000} :
                cae_pkg::BIT_RAM_BASE + {4'h0, i_instr.byte1[6:3]};
        end else if (i_instr.mode == cae_pkg::M_IND) begin
            rd_addr = ptr;
        end
    end
    assign need_mem = (i_instr.op == cae_pkg::OP_BITLD) ||
        ((i_instr.mode == cae_pkg::M_DIR || i_instr.mode == cae_pkg::M_IND)
        && i_instr.op <= cae_pkg::OP_STDN);

    // Operand at execution time
    always_comb begin
        case (ir_reg.mode)
            cae_pkg::M_REG: opnd = bank_mem[{i_bank_sel, ir_reg.reg_idx}];
            cae_pkg::M_IMM: opnd = ir_reg.byte1;
            cae_pkg::M_DIR, cae_pkg::M_IND:
                opnd = int_rd_reg ? bank_mem[o_mem_addr[4:0]] : i_mem_rdata;
            default: opnd = o_acc;
        endcase
    end

    // ******************************************************
    // Arithmetic
    // ******************************************************
    // Carry in only for add-with-carry and subtract-with-borrow
    always_comb begin
        logic cin;
        cin = (ir_reg.op != cae_pkg::OP_ADD) && o_flags.cy;
        sum9 = {1'b0, o_acc} + {1'b0, opnd} + {8'h00, cin};
        sum5 = {1'b0, o_acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
        dif9 = {1'b0, o_acc} - {1'b0, opnd} - {8'h00, cin};
        dif5 = {1'b0, o_acc[3:0]} - {1'b0, opnd[3:0]} - {4'h0, cin};
    end
    assign prod = o_acc * o_aux;
    assign res = (ir_reg.op == cae_pkg::OP_INC) ? opnd + 8'h01 : opnd - 8'h01;

    // Decimal adjust in two steps, low digit then high digit
    assign da_lo = (o_acc[3:0] > cae_pkg::BCD_LIMIT) || o_flags.ac;
    assign da1 = da_lo ? o_acc + cae_pkg::BCD_FIX_LO : o_acc;
    assign da_hi = (da1[7:4] > cae_pkg::BCD_LIMIT) || o_flags.cy ||
        (da_lo && da1 < o_acc);
    assign da2 = da_hi ? da1 + cae_pkg::BCD_FIX_HI : da1;

    // ******************************************************
    // Sequencer
    // ******************************************************
    // Ready is raised for the last ST_RUN cycle so instructions follow back to back; ST_CODE keeps it low until own_ack
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        if (take) begin
            cnt_next = cae_pkg::cae_cycles(i_instr.op, i_instr.mode);
            st_next = (i_instr.op == cae_pkg::OP_IDX) ? ST_CODE : ST_RUN;
        end else if (commit || own_ack) begin
            st_next = ST_IDLE;
        end else if (st_reg == ST_RUN) begin
            cnt_next = cnt_reg - 3'h1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_reg <= ST_IDLE;
            cnt_reg <= 3'h0;
            o_ready <= 1'b1;
            ir_reg <= '0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            o_ready <= (st_next == ST_IDLE) ||
                (st_next == ST_RUN && cnt_next == 3'h1);
            if (take) begin
                ir_reg <= i_instr;
            end
        end
    end

    // Completion strobe and byte length of the retired instruction
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_done <= 1'b0;
            o_len <= 2'h0;
        end else begin
            o_done <= commit || own_ack;
            if (commit || own_ack) begin
                o_len <= cae_pkg::cae_length(ir_reg.op, ir_reg.mode);
            end
        end
    end

    // ******************************************************
    // Data memory port
    // ******************************************************
    // Addresses inside the bank area, below BANK_TOP, are served from the local bank file
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_mem_rd_en <= 1'b0;
            o_mem_wr_en <= 1'b0;
            o_mem_addr <= 8'h00;
            o_mem_wdata <= 8'h00;
            int_rd_reg <= 1'b0;
        end else begin
            o_mem_rd_en <= take && need_mem && rd_addr >= cae_pkg::BANK_TOP;
            o_mem_wr_en <= 1'b0;
            if (take && need_mem) begin
                o_mem_addr <= rd_addr;
                int_rd_reg <= rd_addr < cae_pkg::BANK_TOP;
            end
            if (mid && (ir_reg.op == cae_pkg::OP_INC ||
                    ir_reg.op == cae_pkg::OP_STDN) && !int_rd_reg) begin
                o_mem_wr_en <= 1'b1;
                o_mem_wdata <= res;
            end
        end
    end

    // Bank register file, four banks of eight
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int i = 0; i < 32; i++) begin
                bank_mem[i] <= 8'h00;
            end
        end else if (mid && int_rd_reg && (ir_reg.op == cae_pkg::OP_INC ||
                ir_reg.op == cae_pkg::OP_STDN)) begin
            bank_mem[o_mem_addr[4:0]] <= res;
        end else if (commit && ir_reg.mode == cae_pkg::M_REG &&
                (ir_reg.op == cae_pkg::OP_INC || ir_reg.op == cae_pkg::OP_STDN)) begin
            bank_mem[{i_bank_sel, ir_reg.reg_idx}] <= res;
        end
    end

    // ******************************************************
    // Accumulator, aux operand, wide pointer and flags
    // ******************************************************
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_acc <= cae_pkg::ACC_RST;
            o_aux <= cae_pkg::ACC_RST;
            o_wp <= cae_pkg::WP_RST;
            o_flags <= '0;
        end else if (own_ack) begin
            o_acc <= c_data;
        end else if (commit) begin
            case (ir_reg.op)
                cae_pkg::OP_ADD, cae_pkg::OP_ADC: begin
                    o_acc <= sum9[7:0];
                    o_flags.cy <= sum9[8];
                    o_flags.ac <= sum5[4];
                    o_flags.ov <= (o_acc[7] == opnd[7]) && (sum9[7] != o_acc[7]);
                end
                cae_pkg::OP_SBB: begin
                    o_acc <= dif9[7:0];
                    o_flags.cy <= dif9[8];
                    o_flags.ac <= dif5[4];
                    o_flags.ov <= (o_acc[7] != opnd[7]) && (dif9[7] != o_acc[7]);
                end
                cae_pkg::OP_INC, cae_pkg::OP_STDN: begin
                    if (ir_reg.mode == cae_pkg::M_ACC) begin
                        o_acc <= res;
                    end
                end
                cae_pkg::OP_INCWP: o_wp <= o_wp + 16'h0001;
                cae_pkg::OP_LDWP: o_wp <= {ir_reg.byte1, ir_reg.byte2};
                cae_pkg::OP_PROD: begin
                    o_acc <= prod[7:0];
                    o_aux <= prod[15:8];
                    o_flags.cy <= 1'b0;
                    o_flags.ov <= prod[15:8] != 8'h00;
                end
                cae_pkg::OP_DIV: begin
                    // Divide by zero leaves both operands and flags overflow
                    o_flags.cy <= 1'b0;
                    o_flags.ov <= o_aux == 8'h00;
                    if (o_aux != 8'h00) begin
                        o_acc <= o_acc / o_aux;
                        o_aux <= o_acc % o_aux;
                    end
                end
                cae_pkg::OP_DA: begin
                    o_acc <= da2;
                    o_flags.cy <= da_hi || o_flags.cy;
                end
                cae_pkg::OP_BITLD: o_flags.cy <= opnd[ir_reg.byte1[2:0]];
                default: o_acc <= o_acc;
            endcase
        end
    end

    // ******************************************************
    // Code reads through the cache
    // ******************************************************
    // Fetches are held off while an indexed read owns the cache
    assign code_req = (st_reg == ST_CODE) ? idx_sent_reg : i_fetch_req;
    assign code_addr = (st_reg == ST_CODE) ? o_wp + {8'h00, o_acc} : i_fetch_addr;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            idx_sent_reg <= 1'b0;
            o_fetch_valid <= 1'b0;
            o_fetch_data <= 8'h00;
        end else begin
            if (st_reg != ST_CODE || own_ack) begin
                idx_sent_reg <= 1'b0;
            end else if (c_idle) begin
                idx_sent_reg <= 1'b1;
            end
            o_fetch_valid <= c_ack && !own_ack;
            if (c_ack && !own_ack) begin
                o_fetch_data <= c_data;
            end
        end
    end

    cae_icache #(.DEPTH(CACHE_DEPTH), .AW(cae_pkg::CODE_AW)) u_icache (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_req(code_req),
        .i_addr(code_addr),
        .o_ack(c_ack),
        .o_data(c_data),
        .o_idle(c_idle),
        .o_flash_rd(o_flash_rd),
        .o_flash_addr(o_flash_addr),
        .i_flash_ack(i_flash_ack),
        .i_flash_data(i_flash_data)
    );

    // ******************************************************
    // Assertions
    // ******************************************************
    property p_dir_addr;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        take && i_instr.mode == cae_pkg::M_DIR && i_instr.op <= cae_pkg::OP_STDN
        && i_instr.byte1 >= cae_pkg::BANK_TOP |=>
        o_mem_rd_en && o_mem_addr == $past(i_instr.byte1);
    endproperty
    a_dir_addr: assert property (p_dir_addr) else $error("direct address wrong");

    property p_ind_ptr;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        take && i_instr.mode == cae_pkg::M_IND && i_instr.op <= cae_pkg::OP_STDN
        |=> o_mem_addr == $past(ptr);
    endproperty
    a_ind_ptr: assert property (p_ind_ptr) else $error("indirect pointer wrong");

    property p_add_reg;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        take && i_instr.op == cae_pkg::OP_ADD && i_instr.mode == cae_pkg::M_REG
        |=> ##1 o_done && o_len == cae_pkg::LEN_ONE;
    endproperty
    a_add_reg: assert property (p_add_reg) else $error("add reg timing");

    property p_adc_imm;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        take && i_instr.op == cae_pkg::OP_ADC && i_instr.mode == cae_pkg::M_IMM
        |=> !o_done ##1 !o_done ##1 o_done && o_acc ==
        8'($past(o_acc, 3) + $past(i_instr.byte1, 3) + {7'h00, $past(o_flags.cy, 3)});
    endproperty
    a_adc_imm: assert property (p_adc_imm) else $error("carry add result");

    // Result lands at the retire edge, so it is seen one edge later
    property p_sbb_imm;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        take && i_instr.op == cae_pkg::OP_SBB && i_instr.mode == cae_pkg::M_IMM
        |=> ##2 (o_acc == 8'($past(o_acc, 3) - $past(i_instr.byte1, 3)
        - {7'h00, $past(o_flags.cy, 3)}));
    endproperty
    a_sbb_imm: assert property (p_sbb_imm) else $error("borrow sub result");

    property p_inc_dir;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        take && i_instr.op == cae_pkg::OP_INC && i_instr.mode == cae_pkg::M_DIR
        && i_instr.byte1 >= cae_pkg::BANK_TOP
        |=> !o_mem_wr_en ##1 !o_mem_wr_en ##1 o_mem_wr_en ##1 o_done;
    endproperty
    a_inc_dir: assert property (p_inc_dir) else $error("inc direct timing");

    property p_prod;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        take && i_instr.op == cae_pkg::OP_PROD |=> ##2 o_done &&
        {o_aux, o_acc} == 16'($past(o_acc, 3) * $past(o_aux, 3));
    endproperty
    a_prod: assert property (p_prod) else $error("product wrong");

    property p_div;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        take && i_instr.op == cae_pkg::OP_DIV && o_aux != 8'h00 |=>
        !o_done [*6] ##1 o_done && o_acc == 8'($past(o_acc, 7) / $past(o_aux, 7));
    endproperty
    a_div: assert property (p_div) else $error("quotient wrong");

    c_add_dir: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        take && i_instr.op == cae_pkg::OP_ADD && i_instr.mode == cae_pkg::M_DIR);
    c_idx: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n) own_ack);
    c_b2b: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        commit && take);

endmodule

// >>> rtl/cae_pkg.sv
// Shared types, constants and timing tables of the arithmetic execution unit
package cae_pkg;

    // ******************************************************
    // Opcodes, addressing modes and carriers
    // ******************************************************
    typedef enum logic [3:0] {
        OP_ADD = 4'h0, OP_ADC = 4'h1, OP_SBB = 4'h2, OP_INC = 4'h3,
        OP_STDN = 4'h4, OP_INCWP = 4'h5, OP_PROD = 4'h6, OP_DIV = 4'h7,
        OP_DA = 4'h8, OP_BITLD = 4'h9, OP_IDX = 4'hA, OP_LDWP = 4'hB
    } cae_op_t;

    typedef enum logic [2:0] {
        M_ACC = 3'h0, M_REG = 3'h1, M_DIR = 3'h2, M_IND = 3'h3, M_IMM = 3'h4
    } cae_mode_t;

    typedef struct packed {
        cae_op_t op;
        cae_mode_t mode;
        logic [2:0] reg_idx;
        logic [7:0] byte1;
        logic [7:0] byte2;
    } cae_instr_t;

    typedef struct packed {
        logic cy;
        logic ac;
        logic ov;
    } cae_flags_t;

    // ******************************************************
    // Constants
    // ******************************************************
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [15:0] WP_RST = 16'h0000;
    localparam logic [7:0] BANK_TOP = 8'h20;
    localparam logic [7:0] BIT_RAM_BASE = 8'h20;
    localparam int BIT_SFR_FLAG = 7;
    localparam logic [3:0] BCD_LIMIT = 4'h9;
    localparam logic [7:0] BCD_FIX_LO = 8'h06;
    localparam logic [7:0] BCD_FIX_HI = 8'h60;
    localparam int CACHE_BYTES = 512;
    localparam int CODE_AW = 16;
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_TWO = 3'h2;
    localparam logic [2:0] CYC_THREE = 3'h3;
    localparam logic [2:0] CYC_SIX = 3'h6;
    localparam logic [1:0] LEN_ONE = 2'h1;
    localparam logic [1:0] LEN_TWO = 2'h2;
    localparam logic [1:0] LEN_THREE = 2'h3;

    // Cycle count of each instruction form
    function automatic logic [2:0] cae_cycles(cae_op_t op, cae_mode_t m);
        case (op)
            OP_ADD, OP_ADC, OP_SBB: return (m == M_REG) ? CYC_ONE : CYC_TWO;
            OP_INC, OP_STDN: begin
                if (m == M_ACC) return CYC_ONE;
                if (m == M_REG) return CYC_TWO;
                return CYC_THREE;
            end
            OP_PROD, OP_BITLD: return CYC_TWO;
            OP_DIV: return CYC_SIX;
            OP_DA, OP_LDWP: return CYC_THREE;
            default: return CYC_ONE;
        endcase
    endfunction

    // Byte length of each instruction form
    function automatic logic [1:0] cae_length(cae_op_t op, cae_mode_t m);
        case (op)
            OP_ADD, OP_ADC, OP_SBB:
                return (m == M_REG || m == M_IND) ? LEN_ONE : LEN_TWO;
            OP_INC, OP_STDN: return (m == M_DIR) ? LEN_TWO : LEN_ONE;
            OP_BITLD: return LEN_TWO;
            OP_LDWP: return LEN_THREE;
            default: return LEN_ONE;
        endcase
    endfunction

endpackage

// >>> rtl/cae_icache.sv
// Direct-mapped instruction cache in front of the flash program memory
`timescale 1ns/1ps
module cae_icache #(
    parameter int DEPTH = cae_pkg::CACHE_BYTES,
    parameter int AW = cae_pkg::CODE_AW
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_req,
    input wire logic [AW-1:0] i_addr,
    output logic o_ack,
    output logic [7:0] o_data,
    output logic o_idle,
    output logic o_flash_rd,
    output logic [AW-1:0] o_flash_addr,
    input wire logic i_flash_ack,
    input wire logic [7:0] i_flash_data
);
    localparam int IW = $clog2(DEPTH);
    localparam int TW = AW - IW;

    logic [7:0] data_mem [DEPTH];
    logic [TW-1:0] tag_mem [DEPTH];
    logic [DEPTH-1:0] valid_reg;
    logic [IW-1:0] idx;
    logic hit;
    logic accept;

    // One byte per line keeps the fill to a single flash read
    assign idx = i_addr[IW-1:0];
    assign hit = valid_reg[idx] && (tag_mem[idx] == i_addr[AW-1:IW]);
    assign accept = i_req && !o_flash_rd && !o_ack;
    assign o_idle = !o_flash_rd && !o_ack;

    // Lookup and miss handling
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ack <= 1'b0;
            o_data <= 8'h00;
            o_flash_rd <= 1'b0;
            o_flash_addr <= '0;
            valid_reg <= '0;
        end else begin
            o_ack <= 1'b0;
            if (o_flash_rd && i_flash_ack) begin
                o_flash_rd <= 1'b0;
                o_ack <= 1'b1;
                o_data <= i_flash_data;
                valid_reg[o_flash_addr[IW-1:0]] <= 1'b1;
            end else if (accept && hit) begin
                o_ack <= 1'b1;
                o_data <= data_mem[idx];
            end else if (accept) begin
                o_flash_rd <= 1'b1;
                o_flash_addr <= i_addr;
            end
        end
    end

    // Line storage, no reset needed behind the valid bits
    always_ff @(posedge i_clk_sys) begin
        if (o_flash_rd && i_flash_ack) begin
            data_mem[o_flash_addr[IW-1:0]] <= i_flash_data;
            tag_mem[o_flash_addr[IW-1:0]] <= o_flash_addr[AW-1:IW];
        end
    end

endmodule

// >>> test/cae_mem_model.sv
// Behavioural internal RAM and flash behind the execution unit
`timescale 1ns/1ps
module cae_mem_model (
    input wire logic i_clk_sys,
    input wire logic i_rd_en,
    input wire logic i_wr_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    input wire logic i_flash_rd,
    input wire logic [15:0] i_flash_addr,
    output logic o_flash_ack,
    output logic [7:0] o_flash_data
);
    logic [7:0] ram [0:255];
    logic [1:0] wait_cnt;
    initial begin
        o_rdata = 8'h00;
        o_flash_ack = 1'b0;
        o_flash_data = 8'h00;
        wait_cnt = 2'h0;
    end
    // Byte RAM; read data toggles when not read, so stale data shows
    always @(posedge i_clk_sys) begin
        o_rdata <= i_rd_en ? ram[i_addr] : ~o_rdata;
        if (i_wr_en) begin
            ram[i_addr] <= i_wdata;
        end
    end
    // Slow flash: three cycles per byte, a reason for the code cache
    always @(posedge i_clk_sys) begin
        o_flash_ack <= 1'b0;
        o_flash_data <= ~o_flash_data;
        if (i_flash_rd && !o_flash_ack) begin
            wait_cnt <= wait_cnt + 2'h1;
            if (wait_cnt == 2'h2) begin
                o_flash_ack <= 1'b1;
                o_flash_data <= i_flash_addr[7:0] ^ 8'hA5;
                wait_cnt <= 2'h0;
            end
        end
    end
endmodule

// >>> test/cae_exec_tb.sv
// Self-checking testbench of the arithmetic execution unit
`timescale 1ns/1ps
module cae_exec_tb;
    // ****************************************
    // Clock, reset and wiring
    // ****************************************
    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_issue = 1'b0;
    cae_pkg::cae_instr_t i_instr = '0;
    logic i_fetch_req = 1'b0;
    logic [15:0] i_fetch_addr = 16'h0000;
    logic o_ready, o_done, o_mem_rd_en, o_mem_wr_en, o_fetch_valid;
    logic o_flash_rd, i_flash_ack;
    logic [1:0] o_len;
    logic [7:0] o_acc, o_aux, o_mem_addr, o_mem_wdata, i_mem_rdata;
    logic [7:0] o_fetch_data, i_flash_data;
    logic [15:0] o_wp, o_flash_addr;
    cae_pkg::cae_flags_t o_flags;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    always #25 i_clk_sys = ~i_clk_sys;
    cae_exec cae_exec_i (.i_clk_sys, .i_reset_n, .i_issue, .i_instr,
        .i_bank_sel(2'h0), .o_ready, .o_done, .o_len, .o_acc, .o_aux,
        .o_wp, .o_flags, .o_mem_rd_en, .o_mem_wr_en, .o_mem_addr,
        .o_mem_wdata, .i_mem_rdata, .i_fetch_req, .i_fetch_addr,
        .o_fetch_valid, .o_fetch_data, .o_flash_rd, .o_flash_addr,
        .i_flash_ack, .i_flash_data);
    cae_mem_model cae_mem_model_i (.i_clk_sys(i_clk_sys),
        .i_rd_en(o_mem_rd_en), .i_wr_en(o_mem_wr_en),
        .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata),
        .i_flash_rd(o_flash_rd), .i_flash_addr(o_flash_addr),
        .o_flash_ack(i_flash_ack), .o_flash_data(i_flash_data));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Issue one instruction, then time its retirement against the table
    task automatic run(input cae_pkg::cae_op_t op,
        input cae_pkg::cae_mode_t md, input logic [7:0] b1,
        input int cyc, input int len);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        i_issue <= 1'b1;
        i_instr <= '{op, md, b1[2:0], b1, 8'h00};
        @(posedge i_clk_sys);
        i_issue <= 1'b0;
        while (n < 9) begin
            @(posedge i_clk_sys);
            n++;
            #1;
            if (o_done === 1'b1) break;
        end
        check(16'(n), 16'(cyc));
        check(16'(o_len), 16'(len));
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_add_forms();
        run(cae_pkg::OP_ADD, cae_pkg::M_IMM, 8'h35, 2, 2);
        check(o_acc, 8'h35);
        run(cae_pkg::OP_ADD, cae_pkg::M_DIR, 8'h40, 2, 2);
        check({o_acc, 5'h0, o_flags}, 16'h0006);
        run(cae_pkg::OP_ADC, cae_pkg::M_IMM, 8'h00, 2, 2);
        check({o_acc, 5'h0, o_flags}, 16'h0100);
        run(cae_pkg::OP_SBB, cae_pkg::M_IMM, 8'h02, 2, 2);
        check({o_acc, 5'h0, o_flags}, 16'hFF06);
        $display("t_add_forms done");
    endtask
    task automatic t_bank_forms();
        run(cae_pkg::OP_INC, cae_pkg::M_REG, 8'h03, 2, 1);
        run(cae_pkg::OP_ADD, cae_pkg::M_REG, 8'h03, 1, 1);
        check({o_acc, 5'h0, o_flags}, 16'h0006);
        run(cae_pkg::OP_ADD, cae_pkg::M_IND, 8'h00, 2, 1);
        check({o_acc, 5'h0, o_flags}, 16'h0000);
        $display("t_bank_forms done");
    endtask
    task automatic t_steps();
        run(cae_pkg::OP_INC, cae_pkg::M_ACC, 8'h00, 1, 1);
        run(cae_pkg::OP_STDN, cae_pkg::M_ACC, 8'h00, 1, 1);
        check(o_acc, 8'h00);
        run(cae_pkg::OP_INC, cae_pkg::M_DIR, 8'h50, 3, 2);
        check(cae_mem_model_i.ram[8'h50], 8'h80);
        run(cae_pkg::OP_INCWP, cae_pkg::M_ACC, 8'h00, 1, 1);
        check(o_wp, 16'h0001);
        $display("t_steps done");
    endtask
    task automatic t_mul_div_bcd();
        run(cae_pkg::OP_ADD, cae_pkg::M_IMM, 8'h0A, 2, 2);
        run(cae_pkg::OP_DA, cae_pkg::M_ACC, 8'h00, 3, 1);
        check(o_acc, 8'h10);
        run(cae_pkg::OP_PROD, cae_pkg::M_ACC, 8'h00, 2, 1);
        check({o_acc, o_aux}, 16'h0000);
        run(cae_pkg::OP_DIV, cae_pkg::M_ACC, 8'h00, 6, 1);
        check({o_acc, 6'h0, o_flags.cy, o_flags.ov}, 16'h0001);
        $display("t_mul_div_bcd done");
    endtask
    // Pointer load, bit into carry, then an indexed code read that misses:
    // one setup edge, the cache request, three flash waits and two acks
    task automatic t_ptr_bit_idx();
        run(cae_pkg::OP_LDWP, cae_pkg::M_ACC, 8'h01, 3, 3);
        check(o_wp, 16'h0100);
        run(cae_pkg::OP_BITLD, cae_pkg::M_DIR, 8'h08, 2, 2);
        check(16'(o_flags.cy), 16'h0001);
        run(cae_pkg::OP_IDX, cae_pkg::M_ACC, 8'h00, 7, 1);
        check(o_acc, 8'hA5);
        $display("t_ptr_bit_idx done");
    endtask
    // Same code byte twice: a flash miss, then a quick cache hit
    task automatic t_fetch();
        int n;
        n = 0;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            @(posedge i_clk_sys);
            i_fetch_req <= 1'b1;
            i_fetch_addr <= 16'h0123;
            while (o_fetch_valid !== 1'b1 && n < 40) begin
                @(posedge i_clk_sys);
                n++;
                #1;
            end
            check(o_fetch_data, 8'h86);
            @(posedge i_clk_sys);
            i_fetch_req <= 1'b0;
            repeat (2) @(posedge i_clk_sys);
        end
        check(16'(n <= 4), 16'h0001);
        $display("t_fetch done");
    endtask
    // Hang guard far above the hundred or so cycles the run needs
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        cae_mem_model_i.ram[8'h40] = 8'hCB;
        cae_mem_model_i.ram[8'h50] = 8'h7F;
        cae_mem_model_i.ram[8'h21] = 8'h01;
        repeat (3) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        t_add_forms();
        t_bank_forms();
        t_steps();
        t_mul_div_bcd();
        t_ptr_bit_idx();
        t_fetch();
        complete_run();
    end
endmodule
